// ---- hw/mub_pkg.sv ----
package mub_pkg;

  // ==========================================================================
  // Widths and timing
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned IDENT_W    = 4;
  localparam int unsigned REG_COUNT  = 256;
  // Settle cycles after ready; unused, the controller samples read data in the cycle it sees ready low
  localparam int unsigned SETTLE_CYC = 1;

  // ==========================================================================
  // Reset values of the carrier control outputs
  localparam logic RST_CARRIER_RESET_REQ = 1'b1;
  localparam logic RST_BOOT_OVERRIDE_N   = 1'b1;

  // ==========================================================================
  // Device handshake states
  typedef enum logic [3:0] {
    MUB_D_IDLE  = 4'b0001,
    MUB_D_WRITE = 4'b0010,
    MUB_D_READ  = 4'b0100,
    MUB_D_DONE  = 4'b1000
  } mub_dev_state_t;

  // ==========================================================================
  // Controller states
  typedef enum logic [5:0] {
    MUB_C_IDLE  = 6'b00_0001,
    MUB_C_ADDR  = 6'b00_0010,
    MUB_C_ASTB  = 6'b00_0100,
    MUB_C_STRB  = 6'b00_1000,
    MUB_C_WAIT  = 6'b01_0000,
    MUB_C_END   = 6'b10_0000
  } mub_ctl_state_t;

endpackage : mub_pkg

// ---- hw/mub_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Shared 8-bit multiplexed user port between controller and device
interface mub_if;
  logic [7:0] data_ctl_out;
  logic       data_ctl_oe;
  logic [7:0] data_dev_out;
  logic       data_dev_oe;
  logic       addr_strobe;
  logic       data_strobe_n;
  logic       read_not_write;
  logic       ready_n;

  modport dev (
    input  data_ctl_out, data_ctl_oe, addr_strobe, data_strobe_n, read_not_write,
    output data_dev_out, data_dev_oe, ready_n
  );
  modport ctl (
    input  data_dev_out, data_dev_oe, ready_n,
    output data_ctl_out, data_ctl_oe, addr_strobe, data_strobe_n, read_not_write
  );
endinterface : mub_if
`default_nettype wire

// ---- hw/mub_device.sv ----
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Latch address on address strobe rising edge
// - Controller holds data strobe low per access
// - Direction high reads, low writes
// - Ready low in the same cycle write data latched
// - Ready low after read data driven
// - Carrier reset output held high unless used
// - Boot override low forces carrier operation
// - Flag select chooses almost flag function
// - Carrier reset returns logic to initial state
// - Carrier and module ident are static inputs
module mub_device
  import mub_pkg::*;
#(
  parameter int unsigned NREG = REG_COUNT
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  mub_if.dev                      port,
  input  wire logic               flag_function_select,
  input  wire logic               almost_full_in,
  input  wire logic               almost_empty_in,
  input  wire logic [IDENT_W-1:0] carrier_ident_bit,
  input  wire logic [IDENT_W-1:0] module_ident_bit,
  input  wire logic               user_carrier_reset,
  input  wire logic               user_boot_override,
  output logic                    almost_flag_a,
  output logic                    almost_flag_b,
  output logic                    carrier_reset_request,
  output logic                    carrier_boot_override_n,
  output logic [ADDR_W-1:0]       last_addr,
  output logic [DATA_W-1:0]       last_wdata,
  output logic                    write_pulse,
  output logic [2*IDENT_W-1:0]    ident_seen
);

  // ==========================================================================
  // Input synchronisers
  logic [1:0]        astb_s_r, dstb_s_r, rnw_s_r, fsel_s_r;
  logic [DATA_W-1:0] dat_s1_r, dat_s2_r;
  logic [2*IDENT_W-1:0] id_s1_r, id_s2_r;
  logic              astb_d_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      astb_s_r <= 2'h0;
      dstb_s_r <= 2'h3;
      rnw_s_r  <= 2'h0;
      fsel_s_r <= 2'h0;
      dat_s1_r <= 8'h00;
      dat_s2_r <= 8'h00;
      id_s1_r  <= 8'h00;
      id_s2_r  <= 8'h00;
      astb_d_r <= 1'b0;
    end else begin
      astb_s_r <= {astb_s_r[0], port.addr_strobe};
      dstb_s_r <= {dstb_s_r[0], port.data_strobe_n};
      rnw_s_r  <= {rnw_s_r[0], port.read_not_write};
      fsel_s_r <= {fsel_s_r[0], flag_function_select};
      dat_s1_r <= port.data_ctl_out;
      dat_s2_r <= dat_s1_r;
      id_s1_r  <= {carrier_ident_bit, module_ident_bit};
      id_s2_r  <= id_s1_r;
      astb_d_r <= astb_s_r[1];
    end
  end

  // ==========================================================================
  // Handshake and register file
  mub_dev_state_t    st_r, st_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] mem_r [NREG];
  logic [DATA_W-1:0] rd_r, rd_nxt, wd_r, wd_nxt;
  logic              rdy_n_r, rdy_n_nxt, oe_r, oe_nxt, wp_r, wp_nxt;
  logic              astb_rise, strobe_on;

  assign astb_rise = astb_s_r[1] & ~astb_d_r;
  assign strobe_on = ~dstb_s_r[1];

  // Next-state for the access handshake
  always_comb begin
    st_nxt    = st_r;
    addr_nxt  = addr_r;
    rd_nxt    = rd_r;
    wd_nxt    = wd_r;
    rdy_n_nxt = rdy_n_r;
    oe_nxt    = oe_r;
    wp_nxt    = 1'b0;
    if (astb_rise) begin
      addr_nxt = dat_s2_r;
    end
    unique case (st_r)
      MUB_D_IDLE: begin
        rdy_n_nxt = 1'b1;
        oe_nxt    = 1'b0;
        if (strobe_on && !astb_rise) begin
          if (rnw_s_r[1]) begin
            st_nxt = MUB_D_READ;
            rd_nxt = mem_r[addr_r];
            oe_nxt = 1'b1;
          end else begin
            st_nxt = MUB_D_WRITE;
          end
        end
      end
      MUB_D_WRITE: begin
        wd_nxt    = dat_s2_r;
        wp_nxt    = 1'b1;
        rdy_n_nxt = 1'b0;
        st_nxt    = MUB_D_DONE;
      end
      MUB_D_READ: begin
        rdy_n_nxt = 1'b0;
        st_nxt    = MUB_D_DONE;
      end
      MUB_D_DONE: begin
        if (!strobe_on) begin
          rdy_n_nxt = 1'b1;
          oe_nxt    = 1'b0;
          st_nxt    = MUB_D_IDLE;
        end
      end
      default: begin
        st_nxt    = MUB_D_IDLE;
        rdy_n_nxt = 1'b1;
        oe_nxt    = 1'b0;
      end
    endcase
  end

  // Handshake registers, cleared by carrier reset
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r    <= MUB_D_IDLE;
      addr_r  <= 8'h00;
      rd_r    <= 8'h00;
      wd_r    <= 8'h00;
      rdy_n_r <= 1'b1;
      oe_r    <= 1'b0;
      wp_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      addr_r  <= addr_nxt;
      rd_r    <= rd_nxt;
      wd_r    <= wd_nxt;
      rdy_n_r <= rdy_n_nxt;
      oe_r    <= oe_nxt;
      wp_r    <= wp_nxt;
    end
  end

  // Register storage written at end of a write access
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < NREG; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (wp_r) begin
      mem_r[addr_r] <= wd_r;
    end
  end

  // ==========================================================================
  // Carrier control outputs
  logic crr_r, crr_nxt, boot_n_r, boot_n_nxt, fa_r, fa_nxt, fb_r, fb_nxt;
  logic [2*IDENT_W-1:0] id_r;

  always_comb begin
    crr_nxt    = ~user_carrier_reset;
    boot_n_nxt = ~user_boot_override;
    fa_nxt     = fsel_s_r[1] ? almost_empty_in : almost_full_in;
    fb_nxt     = fsel_s_r[1] ? almost_full_in : almost_empty_in;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crr_r    <= RST_CARRIER_RESET_REQ;
      boot_n_r <= RST_BOOT_OVERRIDE_N;
      fa_r     <= 1'b0;
      fb_r     <= 1'b0;
      id_r     <= 8'h00;
    end else begin
      crr_r    <= crr_nxt;
      boot_n_r <= boot_n_nxt;
      fa_r     <= fa_nxt;
      fb_r     <= fb_nxt;
      id_r     <= id_s2_r;
    end
  end

  assign port.ready_n          = rdy_n_r;
  assign port.data_dev_oe      = oe_r;
  assign port.data_dev_out     = rd_r;
  assign carrier_reset_request = crr_r;
  assign carrier_boot_override_n = boot_n_r;
  assign almost_flag_a         = fa_r;
  assign almost_flag_b         = fb_r;
  assign last_addr             = addr_r;
  assign last_wdata            = wd_r;
  assign write_pulse           = wp_r;
  assign ident_seen            = id_r;

endmodule : mub_device
`default_nettype wire

// ---- hw/mub_controller.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller end: turns one user request into an address phase and an access
module mub_controller
  import mub_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  mub_if.ctl                     port,
  input  wire logic              req_valid,
  input  wire logic              req_read,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata
);

  // ==========================================================================
  // Ready and read data synchronisers
  logic [1:0]        rdy_s_r;
  logic [DATA_W-1:0] din_s1_r, din_s2_r;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdy_s_r  <= 2'h3;
      din_s1_r <= 8'h00;
      din_s2_r <= 8'h00;
    end else begin
      rdy_s_r  <= {rdy_s_r[0], port.ready_n};
      din_s1_r <= port.data_dev_out;
      din_s2_r <= din_s1_r;
    end
  end

  // ==========================================================================
  // Access sequencer
  mub_ctl_state_t    st_r, st_nxt;
  logic [DATA_W-1:0] dout_r, dout_nxt, rsp_r, rsp_nxt;
  logic              oe_r, oe_nxt, as_r, as_nxt, ds_n_r, ds_n_nxt, rnw_r, rnw_nxt;
  logic              rv_r, rv_nxt;

  // Next-state for one access
  always_comb begin
    st_nxt      = st_r;
    dout_nxt    = dout_r;
    rsp_nxt     = rsp_r;
    oe_nxt      = oe_r;
    as_nxt      = as_r;
    ds_n_nxt    = ds_n_r;
    rnw_nxt     = rnw_r;
    rv_nxt      = 1'b0;
    unique case (st_r)
      MUB_C_IDLE: begin
        if (req_valid) begin
          dout_nxt    = req_addr;
          oe_nxt      = 1'b1;
          rnw_nxt     = req_read;
          rsp_nxt     = req_wdata;
          st_nxt      = MUB_C_ADDR;
        end
      end
      MUB_C_ADDR: begin
        as_nxt = 1'b1;
        st_nxt = MUB_C_ASTB;
      end
      MUB_C_ASTB: begin
        as_nxt   = 1'b0;
        dout_nxt = rsp_r;
        oe_nxt   = ~rnw_r;
        st_nxt   = MUB_C_STRB;
      end
      MUB_C_STRB: begin
        ds_n_nxt = 1'b0;
        st_nxt   = MUB_C_WAIT;
      end
      MUB_C_WAIT: begin
        if (!rdy_s_r[1]) begin
          rsp_nxt  = din_s2_r;
          ds_n_nxt = 1'b1;
          oe_nxt   = 1'b0;
          st_nxt   = MUB_C_END;
        end
      end
      MUB_C_END: begin
        if (rdy_s_r[1]) begin
          rv_nxt = rnw_r;
          st_nxt = MUB_C_IDLE;
        end
      end
      default: begin
        st_nxt   = MUB_C_IDLE;
        ds_n_nxt = 1'b1;
        oe_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r      <= MUB_C_IDLE;
      dout_r    <= 8'h00;
      rsp_r     <= 8'h00;
      oe_r      <= 1'b0;
      as_r      <= 1'b0;
      ds_n_r    <= 1'b1;
      rnw_r     <= 1'b0;
      rv_r      <= 1'b0;
    end else begin
      st_r      <= st_nxt;
      dout_r    <= dout_nxt;
      rsp_r     <= rsp_nxt;
      oe_r      <= oe_nxt;
      as_r      <= as_nxt;
      ds_n_r    <= ds_n_nxt;
      rnw_r     <= rnw_nxt;
      rv_r      <= rv_nxt;
    end
  end

  assign port.data_ctl_out   = dout_r;
  assign port.data_ctl_oe    = oe_r;
  assign port.addr_strobe    = as_r;
  assign port.data_strobe_n  = ds_n_r;
  assign port.read_not_write = rnw_r;
  assign req_ready           = (st_r == MUB_C_IDLE);
  assign rsp_valid           = rv_r;
  assign rsp_rdata           = rsp_r;

endmodule : mub_controller
`default_nettype wire

// ---- dv/mub_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module mub_assertions (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [7:0] data_ctl_out,
  input wire logic       data_ctl_oe,
  input wire logic [7:0] data_dev_out,
  input wire logic       data_dev_oe,
  input wire logic       addr_strobe,
  input wire logic       data_strobe_n,
  input wire logic       read_not_write,
  input wire logic       ready_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Handshake and bus ownership
  chk_addr_driven: assert property ($rose(addr_strobe) |-> data_ctl_oe)
    else $error("address strobe without address on bus");
  chk_ready_in_access: assert property ($fell(ready_n) |-> !data_strobe_n)
    else $error("ready outside access");
  chk_ready_bounded: assert property ($fell(data_strobe_n) |-> ##[1:8] !ready_n)
    else $error("ready late");
  chk_read_data_out: assert property ($fell(ready_n) && read_not_write |-> data_dev_oe)
    else $error("read ready without data");
  chk_ready_returns: assert property ($rose(data_strobe_n) |-> ##[1:6] ready_n)
    else $error("ready stuck low");
  chk_one_driver: assert property (!(data_dev_oe && data_ctl_oe))
    else $error("both ends drive data");
  chk_write_no_drive: assert property (!data_strobe_n && !read_not_write |-> !data_dev_oe)
    else $error("device drives in write");
  chk_oe_read_only: assert property ($rose(data_dev_oe) |-> read_not_write && !data_strobe_n)
    else $error("device drives outside read");
  chk_idle_after_reset: assert property ($fell(reset) |-> ready_n && !data_dev_oe)
    else $error("port not idle after reset");
endmodule : mub_assertions
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mub_pkg::*;
  logic sys_clk = 0, reset = 1, req_valid = 0, req_read = 0, req_ready, rsp_valid;
  logic [7:0] req_addr = 0, req_wdata = 0, rsp_rdata, last_addr, last_wdata, ident_seen;
  logic fsel = 0, a_full = 1, a_empty = 0, u_crst = 0, u_boot = 0;
  logic flag_a, flag_b, crst_req, boot_n, write_pulse;
  logic [3:0] cid = 4'h5, mid = 4'hA;
  int fail_count = 0, comparisons = 0, cyc = 0;
  logic [7:0] rd;
  mub_if bus ();
  mub_controller mub_controller_inst (.sys_clk(sys_clk), .reset(reset), .port(bus.ctl),
    .req_valid(req_valid), .req_read(req_read), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  mub_device mub_device_inst (.sys_clk(sys_clk), .reset(reset), .port(bus.dev),
    .flag_function_select(fsel), .almost_full_in(a_full), .almost_empty_in(a_empty),
    .carrier_ident_bit(cid), .module_ident_bit(mid), .user_carrier_reset(u_crst),
    .user_boot_override(u_boot), .almost_flag_a(flag_a), .almost_flag_b(flag_b),
    .carrier_reset_request(crst_req), .carrier_boot_override_n(boot_n),
    .last_addr(last_addr), .last_wdata(last_wdata), .write_pulse(write_pulse),
    .ident_seen(ident_seen));
  mub_assertions mub_assertions_inst (.sys_clk(sys_clk), .reset(reset),
    .data_ctl_out(bus.data_ctl_out), .data_ctl_oe(bus.data_ctl_oe),
    .data_dev_out(bus.data_dev_out), .data_dev_oe(bus.data_dev_oe),
    .addr_strobe(bus.addr_strobe), .data_strobe_n(bus.data_strobe_n),
    .read_not_write(bus.read_not_write), .ready_n(bus.ready_n));
  // Clock
  always #2.5 sys_clk = ~sys_clk;
  // ==========
  // Tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Pick one of the flags that the bench waits for
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = req_ready;
      1: pick = rsp_valid;
      default: pick = write_pulse;
    endcase
  endfunction : pick
  // Wait at falling edges for a flag, bounded; a timeout counts as a mismatch
  task automatic wait_hi(input int sel);
    int n;
    n = 0;
    while (pick(sel) !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    if (pick(sel) !== 1'b1) begin
      fail_count++;
      $display("mismatch wait flag %0d expected 1 seen 0", sel);
    end
  endtask : wait_hi
  // One access through the controller
  task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req_valid = 1;
    req_read = r;
    req_addr = a;
    req_wdata = d;
    wait_hi(0);
    @(negedge sys_clk);
    req_valid = 0;
    if (r) begin
      wait_hi(1);
    end else begin
      wait_hi(2);
      check("ready_n", {7'h00, bus.ready_n}, 8'h00);
    end
    rd = rsp_rdata;
    wait_hi(0);
  endtask : xfer
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  // Cycle ceiling
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // ==========
  // Main sequence
  initial begin
    repeat (6) @(negedge sys_clk);
    reset = 0;
    idle(6);
    check("crst_req", {7'h00, crst_req}, 8'h01);
    check("boot_n", {7'h00, boot_n}, 8'h01);
    check("ident", ident_seen, 8'h5A);
    xfer(0, 8'h00, 8'hC3);
    check("last_addr", last_addr, 8'h00);
    check("last_wdata", last_wdata, 8'hC3);
    xfer(0, 8'hFF, 8'h3C);
    check("last_addr", last_addr, 8'hFF);
    xfer(1, 8'h00, 8'h00);
    check("rdata", rd, 8'hC3);
    xfer(1, 8'hFF, 8'h00);
    check("rdata", rd, 8'h3C);
    check("flags", {6'h00, flag_a, flag_b}, 8'h02);
    fsel = 1;
    idle(6);
    check("flags", {6'h00, flag_a, flag_b}, 8'h01);
    u_crst = 1;
    u_boot = 1;
    idle(4);
    check("crst_req", {7'h00, crst_req}, 8'h00);
    check("boot_n", {7'h00, boot_n}, 8'h00);
    reset = 1;
    idle(2);
    check("crst_req", {7'h00, crst_req}, 8'h01);
    check("ready_n", {7'h00, bus.ready_n}, 8'h01);
    u_crst = 0;
    u_boot = 0;
    reset = 0;
    idle(6);
    xfer(1, 8'h00, 8'h00);
    check("rdata", rd, 8'h00);
    check("ready_n", {7'h00, bus.ready_n}, 8'h01);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
